// ---- core/sba_regs.svh ----
// Constants for the shared slave burst arbiter and its bursting master.
// Included by the package, the arbiter and the master; definitions only.
`ifndef SBA_REGS_SVH
`define SBA_REGS_SVH
`define SBA_AW 16
`define SBA_DW 32
`define SBA_BEW 4
`define SBA_BCW 4
`define SBA_SHW 4
`define SBA_PTRW 2
`define SBA_CNTW 3
`define SBA_LAT_MAX 8
`define SBA_BUF_AW 3
`define SBA_MAX_PEND 3'h4
`define SBA_ONE_PEND 3'h1
`define SBA_SLV_MAXB 4'h2
`define SBA_ONE_BEAT 4'h1
`define SBA_ONE_SHARE 4'h1
`endif

// ---- core/sba_pkg.sv ----
// Types shared by the arbiter, the bursting master and their interface.
// Assumes the constants header sits beside it on the include path.
`include "sba_regs.svh"
package sba_pkg;
   typedef logic [`SBA_AW-1:0] sba_addr_t;
   typedef logic [`SBA_DW-1:0] sba_data_t;
   typedef logic [`SBA_BEW-1:0] sba_be_t;
   typedef logic [`SBA_BCW-1:0] sba_bc_t;

   typedef struct packed {
      logic id;
      sba_bc_t len;
      logic last;
   } sba_tag_t;

   typedef struct packed {
      logic gnt;
      logic [`SBA_SHW-1:0] used;
      logic lock;
      sba_bc_t wr_left;
      sba_bc_t sub_left;
      sba_addr_t beat_addr;
      logic rd_act;
      logic rd_id;
      sba_bc_t rd_left;
      sba_addr_t rd_addr;
      logic s_read;
      logic s_write;
      sba_addr_t s_addr;
      sba_bc_t s_bcount;
      sba_be_t s_be;
      sba_data_t s_wdata;
      sba_tag_t [`SBA_MAX_PEND-1:0] tags;
      logic [`SBA_PTRW-1:0] wp;
      logic [`SBA_PTRW-1:0] rp;
      logic [`SBA_CNTW-1:0] cnt;
      sba_bc_t got;
      logic [`SBA_LAT_MAX-1:0] lat_sh;
      logic [1:0] blk;
      logic [1:0] m_wait;
      logic [1:0] m_rdv;
      sba_data_t m_rdata;
   } sba_arb_st_t;

   localparam sba_arb_st_t SBA_ARB_RST = '{m_wait: 2'b11, default: '0};

   typedef enum logic [3:0] {
      SBA_MS_IDLE = 4'b0001,
      SBA_MS_WR = 4'b0010,
      SBA_MS_RD = 4'b0100,
      SBA_MS_RWAIT = 4'b1000
   } sba_ms_state_t;

   typedef struct packed {
      sba_ms_state_t state;
      logic read;
      logic write;
      sba_addr_t addr;
      sba_bc_t bcount;
      sba_be_t be;
      sba_data_t wdata;
      sba_data_t [`SBA_LAT_MAX-1:0] words;
      sba_bc_t fill;
      sba_bc_t beat;
      sba_bc_t left;
      sba_data_t rd_data;
      logic rd_valid;
      logic done;
   } sba_mst_st_t;

   localparam sba_mst_st_t SBA_MST_RST = '{state: SBA_MS_IDLE, default: '0};
endpackage : sba_pkg

// ---- core/sba_if.sv ----
// One master port of the shared slave: command, write data and read return.
// A request is taken on a clock edge where read or write is high and wait_req low.
`timescale 1ns/1ps
interface sba_if;
   import sba_pkg::*;
   logic read;
   logic write;
   sba_addr_t addr;
   sba_bc_t bcount;
   sba_be_t be;
   sba_data_t wdata;
   logic wait_req;
   sba_data_t rdata;
   logic rdvalid;
   modport arb (input read, write, addr, bcount, be, wdata, output wait_req, rdata, rdvalid);
   modport mst (output read, write, addr, bcount, be, wdata, input wait_req, rdata, rdvalid);
endinterface : sba_if

// ---- core/sba_arbiter.sv ----
// Arbiter, burst splitter and read return logic in front of one shared slave.
// Two masters join through sba_if; the slave pins are plain ports, one clock.
`timescale 1ns/1ps
`include "sba_regs.svh"
module sba_arbiter
   import sba_pkg::*;
#(
   parameter logic [`SBA_SHW-1:0] SHARE0 = `SBA_ONE_SHARE,
   parameter logic [`SBA_SHW-1:0] SHARE1 = `SBA_ONE_SHARE,
   parameter bit M0_PIPE = 1'b1,
   parameter bit M1_PIPE = 1'b1,
   parameter bit SLV_PIPE = 1'b1,
   parameter bit SLV_BURST = 1'b1,
   parameter int SLV_LAT = 0
) (
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   sba_if.arb m0,
   sba_if.arb m1,
   output logic s_read,
   output logic s_write,
   output sba_addr_t s_addr,
   output sba_bc_t s_bcount,
   output sba_be_t s_be,
   output sba_data_t s_wdata,
   input wire logic s_waitreq,
   input wire sba_data_t s_rdata,
   input wire logic s_rdvalid
);
   // Fixed latency slaves return one word per read, so they never see bursts
   localparam sba_bc_t CAP = (!SLV_BURST || SLV_LAT != 0) ? `SBA_ONE_BEAT
                                                         : `SBA_SLV_MAXB;
   localparam logic [`SBA_CNTW-1:0] LIM = SLV_PIPE ? `SBA_MAX_PEND : `SBA_ONE_PEND;
   localparam int LAT_IDX = (SLV_LAT > 0) ? SLV_LAT - 1 : 0;

   sba_arb_st_t st;
   sba_arb_st_t nx;
   logic [1:0] req;
   logic [1:0] wr_req;
   sba_addr_t m_addr [2];
   sba_bc_t m_bc [2];
   sba_be_t m_be [2];
   sba_data_t m_wd [2];

   function automatic sba_bc_t clip(input sba_bc_t left);
      clip = (left > CAP) ? CAP : left;
   endfunction : clip

   function automatic logic [`SBA_SHW-1:0] share_of(input logic id);
      share_of = id ? SHARE1 : SHARE0;
   endfunction : share_of

   function automatic logic pipe_of(input logic id);
      pipe_of = id ? M1_PIPE : M0_PIPE;
   endfunction : pipe_of

   assign req = {m1.read | m1.write, m0.read | m0.write};
   assign wr_req = {m1.write, m0.write};
   assign m_addr[0] = m0.addr;
   assign m_addr[1] = m1.addr;
   assign m_bc[0] = m0.bcount;
   assign m_bc[1] = m1.bcount;
   assign m_be[0] = m0.be;
   assign m_be[1] = m1.be;
   assign m_wd[0] = m0.wdata;
   assign m_wd[1] = m1.wdata;

   always_comb begin
      sba_tag_t head;
      logic rsp_v;
      logic acc;
      logic g;
      logic [1:0] avail;
      sba_bc_t sub;
      sba_bc_t total;
      sba_addr_t a;
      nx = st;
      head = st.tags[st.rp];
      g = st.gnt;
      sub = '0;
      total = '0;
      a = '0;
      avail = '0;
      rsp_v = 1'b0;
      acc = 1'b0;
      nx.m_rdv = '0;
      // Slave accepts the held command when its wait request is low
      if ((st.s_read || st.s_write) && !s_waitreq) begin
         nx.s_read = 1'b0;
         nx.s_write = 1'b0;
      end
      nx.lat_sh = {st.lat_sh[`SBA_LAT_MAX-2:0], st.s_read && !s_waitreq};
      rsp_v = (SLV_LAT == 0) ? s_rdvalid : st.lat_sh[LAT_IDX];
      // Return each word to the master at the head of the tag FIFO
      if (rsp_v && st.cnt != '0) begin
         nx.m_rdata = s_rdata;
         nx.m_rdv[head.id] = 1'b1;
         if (st.got + `SBA_ONE_BEAT == head.len) begin
            nx.got = '0;
            nx.rp = st.rp + 1'b1;
            nx.cnt = st.cnt - 1'b1;
            if (head.last) begin
               nx.blk[head.id] = 1'b0;
            end
         end else begin
            nx.got = st.got + `SBA_ONE_BEAT;
         end
      end
      acc = req[g] && !st.m_wait[g];
      if (acc && wr_req[g]) begin
         // Base address taken fresh at each burst start, no ordering kept
         if (st.wr_left == '0) begin
            total = m_bc[g];
            a = m_addr[g];
         end else begin
            total = st.wr_left;
            a = st.beat_addr;
         end
         if (st.sub_left == '0) begin
            sub = clip(total);
            nx.s_bcount = sub;
            nx.s_addr = a;
            nx.sub_left = sub - 1'b1;
         end else begin
            nx.sub_left = st.sub_left - 1'b1;
         end
         nx.s_write = 1'b1;
         nx.s_be = m_be[g];
         nx.s_wdata = m_wd[g];
         nx.beat_addr = a + 1'b1;
         nx.wr_left = total - 1'b1;
         nx.lock = (total != `SBA_ONE_BEAT);
         if (total == `SBA_ONE_BEAT) begin
            nx.used = st.used + 1'b1;
         end
      end else if (acc) begin
         nx.rd_act = 1'b1;
         nx.rd_id = g;
         nx.rd_left = m_bc[g];
         nx.rd_addr = m_addr[g];
         nx.s_be = m_be[g];
         nx.used = st.used + 1'b1;
         if (!pipe_of(g)) begin
            nx.blk[g] = 1'b1;
         end
      end else if (st.rd_act && !(nx.s_read || nx.s_write) && nx.cnt < LIM) begin
         // One slave read per sub-burst, each tagged with its owner
         sub = clip(st.rd_left);
         nx.s_read = 1'b1;
         nx.s_addr = st.rd_addr;
         nx.s_bcount = sub;
         nx.tags[st.wp] = '{id: st.rd_id, len: sub, last: (st.rd_left == sub)};
         nx.wp = st.wp + 1'b1;
         nx.cnt = nx.cnt + 1'b1;
         nx.rd_left = st.rd_left - sub;
         nx.rd_addr = st.rd_addr + sub;
         if (st.rd_left == sub) begin
            nx.rd_act = 1'b0;
         end
      end
      // Arbitrate only between bursts; a locked grant never moves
      if (!nx.lock && !nx.rd_act) begin
         avail = req & ~nx.blk;
         if (!avail[g] && avail[!g]) begin
            nx.gnt = !g;
            nx.used = '0;
         end else if (nx.used >= share_of(g)) begin
            nx.used = '0;
            if (avail[!g]) begin
               nx.gnt = !g;
            end
         end
      end
      // Ready is predicted a cycle ahead so the master sees it from a flop
      nx.m_wait[0] = nx.gnt || nx.s_read || nx.s_write || nx.rd_act || nx.blk[0]
                     || !(nx.cnt < LIM);
      nx.m_wait[1] = !nx.gnt || nx.s_read || nx.s_write || nx.rd_act || nx.blk[1]
                     || !(nx.cnt < LIM);
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st <= SBA_ARB_RST;
      end else if (ce) begin
         st <= nx;
      end
   end

   assign m0.wait_req = st.m_wait[0];
   assign m0.rdata = st.m_rdata;
   assign m0.rdvalid = st.m_rdv[0];
   assign m1.wait_req = st.m_wait[1];
   assign m1.rdata = st.m_rdata;
   assign m1.rdvalid = st.m_rdv[1];
   assign s_read = st.s_read;
   assign s_write = st.s_write;
   assign s_addr = st.s_addr;
   assign s_bcount = st.s_bcount;
   assign s_be = st.s_be;
   assign s_wdata = st.s_wdata;
endmodule : sba_arbiter

// ---- core/sba_master.sv ----
// Bursting master end: buffers a burst of words and writes it, or reads a burst.
// Drives one sba_if port; the user side loads words and starts transfers.
`timescale 1ns/1ps
`include "sba_regs.svh"
module sba_master
   import sba_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic ce,
   sba_if.mst bus,
   input wire logic push,
   input wire sba_data_t push_data,
   input wire logic go,
   input wire logic go_write,
   input wire sba_addr_t go_addr,
   input wire sba_bc_t go_len,
   input wire sba_be_t go_be,
   output logic busy,
   output logic done,
   output sba_bc_t fill,
   output sba_data_t rd_data,
   output logic rd_valid
);
   sba_mst_st_t st;
   sba_mst_st_t nx;

   always_comb begin
      nx = st;
      nx.done = 1'b0;
      nx.rd_valid = 1'b0;
      unique case (st.state)
         SBA_MS_IDLE: begin
            if (push && st.fill != `SBA_LAT_MAX) begin
               nx.words[st.fill[`SBA_BUF_AW-1:0]] = push_data;
               nx.fill = st.fill + `SBA_ONE_BEAT;
            end
            // Each start is a fresh base and count, never a continuation
            if (go && go_len != '0) begin
               nx.addr = go_addr;
               nx.bcount = go_len;
               nx.be = go_be;
               nx.beat = '0;
               nx.left = go_len;
               if (!go_write) begin
                  nx.read = 1'b1;
                  nx.state = SBA_MS_RD;
               end else if (st.fill >= go_len) begin
                  nx.write = 1'b1;
                  nx.wdata = st.words[0];
                  nx.state = SBA_MS_WR;
               end
            end
         end
         SBA_MS_WR: begin
            // Write stays high between beats; only wait_req pauses it
            if (!bus.wait_req) begin
               nx.beat = st.beat + `SBA_ONE_BEAT;
               if (st.beat + `SBA_ONE_BEAT == st.bcount) begin
                  nx.write = 1'b0;
                  nx.fill = '0;
                  nx.done = 1'b1;
                  nx.state = SBA_MS_IDLE;
               end else begin
                  nx.wdata = st.words[nx.beat[`SBA_BUF_AW-1:0]];
               end
            end
         end
         SBA_MS_RD: begin
            if (!bus.wait_req) begin
               nx.read = 1'b0;
               nx.state = SBA_MS_RWAIT;
            end
         end
         SBA_MS_RWAIT: begin
            if (bus.rdvalid) begin
               nx.rd_data = bus.rdata;
               nx.rd_valid = 1'b1;
               nx.left = st.left - `SBA_ONE_BEAT;
               if (st.left == `SBA_ONE_BEAT) begin
                  nx.done = 1'b1;
                  nx.state = SBA_MS_IDLE;
               end
            end
         end
      endcase
   end

   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         st <= SBA_MST_RST;
      end else if (ce) begin
         st <= nx;
      end
   end

   // Address, count and byte enables only change in idle
   assign bus.addr = st.addr;
   assign bus.bcount = st.bcount;
   assign bus.be = st.be;
   assign bus.read = st.read;
   assign bus.write = st.write;
   assign bus.wdata = st.wdata;
   assign busy = (st.state != SBA_MS_IDLE);
   assign done = st.done;
   assign fill = st.fill;
   assign rd_data = st.rd_data;
   assign rd_valid = st.rd_valid;
endmodule : sba_master

// ---- test/sba_port_sva.sv ----
// Assertion checker for one master port of the shared slave arbiter.
// Instantiated by the bench beside the port interface; inputs are its signals.
`timescale 1ns/1ps
module sba_port_sva
   import sba_pkg::*;
(
   input wire logic clock,
   input wire logic rst,
   input wire logic read,
   input wire logic write,
   input wire sba_addr_t addr,
   input wire sba_bc_t bcount,
   input wire sba_be_t be,
   input wire logic wait_req,
   input wire logic rdvalid
);
   logic [5:0] pend;
   sba_bc_t wb;
   sba_bc_t bc;
   sba_addr_t base;
   wire logic rd_take = read && !wait_req;
   wire logic wr_take = write && !wait_req;

   // Words owed to this port, and position inside the current write burst
   always_ff @(posedge clock or posedge rst) begin
      if (rst) begin
         pend <= '0;
         wb <= '0;
         bc <= '0;
         base <= '0;
      end else begin
         pend <= pend + (rd_take ? 6'(bcount) : 6'h00) - (rdvalid ? 6'h01 : 6'h00);
         if (wr_take) begin
            if (wb == 4'h0) begin
               base <= addr;
               bc <= bcount;
            end
            wb <= (wb + 4'h1 == bcount) ? 4'h0 : wb + 4'h1;
         end
      end
   end

   default clocking @(posedge clock); endclocking
   default disable iff (rst);

   property p_rd_hold; read && wait_req |=> read && $stable(addr) && $stable(bcount); endproperty
   a_rd_hold: assert property (p_rd_hold) else $error("read request dropped");
   property p_wr_hold;
      write && wait_req |=> write && $stable(be) && $stable(bcount) && $stable(addr);
   endproperty
   a_wr_hold: assert property (p_wr_hold) else $error("write beat changed");
   property p_bc_legal; read || write |-> bcount != 4'h0 && bcount <= 4'h8; endproperty
   a_bc_legal: assert property (p_bc_legal) else $error("burst count out of range");
   property p_take_wait; rd_take || wr_take |=> wait_req; endproperty
   a_take_wait: assert property (p_take_wait) else $error("no wait after take");
   property p_burst_const; wr_take && wb != 4'h0 |-> addr == base && bcount == bc; endproperty
   a_burst_const: assert property (p_burst_const) else $error("burst base moved");
   property p_rd_pending; rdvalid |-> pend != 6'h00; endproperty
   a_rd_pending: assert property (p_rd_pending) else $error("word not asked for");
   property p_rd_return; pend != 6'h00 |-> ##[0:300] rdvalid; endproperty
   a_rd_return: assert property (p_rd_return) else $error("read word lost");
   property p_grant; read || write |-> ##[0:300] !wait_req; endproperty
   a_grant: assert property (p_grant) else $error("request starved");
endmodule : sba_port_sva

// ---- test/shared_slave_burst_arbiter_tb.sv ----
// Two bursting masters share one slave model through the arbiter.
// Master 0 uses the lower address half, master 1 the upper half.
`timescale 1ns/1ps
module shared_slave_burst_arbiter_tb;
   import sba_pkg::*;
   logic clock;
   logic rst;
   logic ce;
   logic [1:0] push, go, go_write, busy, done, rd_valid;
   sba_data_t push_data [2];
   sba_addr_t go_addr [2];
   sba_bc_t go_len [2];
   sba_be_t go_be [2];
   sba_bc_t fill [2];
   sba_data_t rd_data [2];
   sba_bc_t len_of [2];
   logic s_read, s_write, s_waitreq, s_rdvalid, own;
   sba_addr_t s_addr;
   sba_bc_t s_bcount, sb, wl;
   sba_be_t s_be;
   sba_data_t s_wdata, s_rdata;
   sba_data_t rq [$];
   int mismatches, n_tests, seed;
   sba_if bus0();
   sba_if bus1();

   sba_master i_sba_master_0 (.clock(clock), .rst(rst), .ce(ce), .bus(bus0),
      .push(push[0]), .push_data(push_data[0]), .go(go[0]), .go_write(go_write[0]),
      .go_addr(go_addr[0]), .go_len(go_len[0]), .go_be(go_be[0]), .busy(busy[0]),
      .done(done[0]), .fill(fill[0]), .rd_data(rd_data[0]), .rd_valid(rd_valid[0]));
   sba_master i_sba_master_1 (.clock(clock), .rst(rst), .ce(ce), .bus(bus1),
      .push(push[1]), .push_data(push_data[1]), .go(go[1]), .go_write(go_write[1]),
      .go_addr(go_addr[1]), .go_len(go_len[1]), .go_be(go_be[1]), .busy(busy[1]),
      .done(done[1]), .fill(fill[1]), .rd_data(rd_data[1]), .rd_valid(rd_valid[1]));
   // Master 0 weighted double and master 1 non-pipelined, so those paths are reached
   sba_arbiter #(.SHARE0(4'h2), .M1_PIPE(1'b0)) i_sba_arbiter (.clock(clock), .rst(rst),
      .ce(ce), .m0(bus0), .m1(bus1),
      .s_read(s_read), .s_write(s_write), .s_addr(s_addr), .s_bcount(s_bcount), .s_be(s_be),
      .s_wdata(s_wdata), .s_waitreq(s_waitreq), .s_rdata(s_rdata), .s_rdvalid(s_rdvalid));
   sba_port_sva i_sba_port_sva (.clock(clock), .rst(rst), .read(bus0.read),
      .write(bus0.write), .addr(bus0.addr), .bcount(bus0.bcount), .be(bus0.be),
      .wait_req(bus0.wait_req), .rdvalid(bus0.rdvalid));

   function automatic sba_data_t word_of(input sba_addr_t a);
      return {a ^ 16'h5a5a, a};
   endfunction : word_of

   task automatic check(input string what, input sba_data_t exp, input sba_data_t got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : check

   task automatic report_and_stop();
      $display("mismatches %0d n_tests %0d", mismatches, n_tests);
      if (mismatches == 0 && n_tests > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask : report_and_stop

   initial begin
      clock = 1'b0;
      forever #2 clock = ~clock;
   end

   // Slave model: takes at the falling edge, where the held command has settled;
   // sampling at the rising edge would race the arbiter's own output flops
   always @(negedge clock) begin
      if (!rst && !s_waitreq && (s_read || s_write)) begin
         check("slave burst", 32'h0000_0001, 32'(s_bcount != 4'h0 && s_bcount <= 4'h2));
         if (s_write && wl == 4'h0) begin
            own = s_addr[15];
            wl = len_of[own];
         end
         if (wl != 4'h0)
            check("grant owner", 32'(own), 32'(s_addr[15]));
         if (s_write) begin
            check("slave wdata", word_of(s_addr + 16'(sb)), s_wdata);
            check("slave be", 32'h0000_000f, 32'(s_be));
            sb = (sb + 4'h1 == s_bcount) ? 4'h0 : sb + 4'h1;
            wl = wl - 4'h1;
         end else begin
            for (int i = 0; i < s_bcount; i++)
               rq.push_back(word_of(s_addr + 16'(i)));
         end
      end
   end

   // Random stalls and variable read latency; waits when pending words near full
   always @(posedge clock) begin
      #1;
      s_waitreq = (($random(seed) & 3) == 0) || (rq.size() > 6);
      if (rq.size() != 0 && ($random(seed) & 1)) begin
         s_rdvalid = 1'b1;
         s_rdata = rq.pop_front();
      end else begin
         s_rdvalid = 1'b0;
         s_rdata = ~s_rdata;
      end
   end

   task automatic run_op(input int m, input logic wr, input sba_bc_t len);
      sba_addr_t a;
      int k;
      int t;
      a = {m[0], 3'h0, 12'($random(seed))};
      if (wr) begin
         for (k = 0; k < len; k++) begin
            push[m] = 1'b1;
            push_data[m] = word_of(a + 16'(k));
            @(posedge clock);
            #1;
         end
         push[m] = 1'b0;
         len_of[m] = len;
         check("buffer fill", 32'(len), 32'(fill[m]));
      end
      go[m] = 1'b1;
      go_write[m] = wr;
      go_addr[m] = a;
      go_len[m] = len;
      @(posedge clock);
      #1;
      go[m] = 1'b0;
      check("busy", 32'h0000_0001, 32'(busy[m]));
      k = 0;
      for (t = 0; t < 500; t++) begin
         @(posedge clock);
         #1;
         if (rd_valid[m] === 1'b1) begin
            check("read data", word_of(a + 16'(k)), rd_data[m]);
            k++;
         end
         if (done[m] === 1'b1)
            break;
      end
      if (t == 500) begin
         mismatches++;
         report_and_stop();
      end
      check("busy end", 32'h0000_0000, 32'(busy[m]));
      if (!wr)
         check("read words", 32'(len), 32'(k));
      @(posedge clock);
      #1;
   endtask : run_op

   task automatic drive(input int m);
      run_op(m, 1'b1, 4'h8);
      run_op(m, 1'b0, 4'h8);
      run_op(m, 1'b0, 4'h1);
      repeat (14) run_op(m, 1'($random(seed)), 4'(1 + ($random(seed) & 7)));
   endtask : drive

   initial begin
      seed = 72639;
      mismatches = 0;
      n_tests = 0;
      rst = 1'b1;
      ce = 1'b1;
      push = '0;
      go = '0;
      go_write = '0;
      push_data = '{default: '0};
      go_addr = '{default: '0};
      go_len = '{default: 4'h1};
      go_be = '{default: 4'hf};
      len_of = '{default: '0};
      s_waitreq = 1'b1;
      s_rdvalid = 1'b0;
      s_rdata = '0;
      sb = '0;
      wl = '0;
      own = 1'b0;
      repeat (3) @(posedge clock);
      #1;
      rst = 1'b0;
      fork
         drive(0);
         drive(1);
      join
      report_and_stop();
   end
endmodule : shared_slave_burst_arbiter_tb
